// file: hdl/tasd_defs.vh
// Purpose: Offsets, field positions, reset values and timing counts of the trim and swap delay registers
// Assumes: Included by bare name; definitions only
// Notes: Offsets are byte addresses on an 8-bit register port
`ifndef TASD_DEFS_VH
`define TASD_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TASD_ADDR_W 9
`define TASD_OFS_GAIN 9'h07A
`define TASD_OFS_REF 9'h07C
`define TASD_OFS_TERM_A 9'h07E
`define TASD_OFS_TERM_B 9'h07F
`define TASD_OFS_TERM_C 9'h080
`define TASD_OFS_TERM_D 9'h081
`define TASD_OFS_OVLP 9'h09A
`define TASD_OFS_STEER 9'h09B
`define TASD_OFS_SWAP_CTRL 9'h0A0
`define TASD_OFS_SWAP_STAT 9'h0A1

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define TASD_REF_MSB 3
`define TASD_DLY_MSB 4
`define TASD_CTRL_CAL_EN 0
`define TASD_CTRL_SWAP_GO 1
`define TASD_STAT_OVLP 0
`define TASD_STAT_STEER 1
`define TASD_STAT_BUSY 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TASD_RST_OVLP 5'h08
`define TASD_RST_STEER 5'h07
`define TASD_RST_CTRL 8'h00

// ----------------------------------------
// Timing counts, in converter clock cycles
// ----------------------------------------
`define TASD_OVLP_BASE 7'h04
`define TASD_CNT_W 7

`endif

// file: hdl/tasd_regs.v
// Purpose: Trim and background swap delay register bank for a multi-core converter
// Assumes: Single clock i_clk; synchronous active-high reset; fuse values stable at reset release
// Notes: Byte-wide register port, read data valid the cycle after the read strobe
//
// Functional notes
// - Eight-bit gain trim register acts on all converter cores together.
// - Four-bit reference trim in bits 3:0; bits 7:4 reserved, written zero.
// - Trim registers load fuse values after reset; readable and overwritable.
// - Four termination trim registers, each driving only its own input channel.
// - Swap overlap lasts four plus twice overlap delay converter cycles.
// - Overlap delay is five bits, 0 to 31, reset 0x08; upper bits reserved.
// - Steering delay five bits, reset 0x07, delays selector, only during swaps.
`timescale 1ns/1ps
`include "tasd_defs.vh"

module tasd_regs #(
  parameter ADDR_W = `TASD_ADDR_W
)(
  input wire i_clk,
  input wire i_srst,
  // Register port
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Factory fuse values
  input wire [7:0] i_fuse_gain,
  input wire [3:0] i_fuse_ref,
  input wire [31:0] i_fuse_term,
  // Trim outputs to the analog circuits
  output wire [7:0] o_core_gain_adjust,
  output wire [3:0] o_reference_voltage_adjust,
  output wire [31:0] o_termination_adjust,
  // Swap controls
  input wire i_swap_req,
  output wire o_calibration_enable,
  output wire o_swap_overlap,
  output wire o_steer_wait,
  output wire o_steer_sel,
  output wire o_swap_busy
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] gain_q;
  reg [3:0] ref_q;
  reg [4:0] ovlp_q;
  reg [4:0] steer_q;
  reg [7:0] ctrl_q;
  reg fuse_load_q;
  reg swap_go_q;
  reg [2:0] req_sync_q;
  reg req_lvl_q;
  reg [7:0] rdata_d;

  wire wr_gain = i_wr && (i_addr == `TASD_OFS_GAIN);
  wire wr_ref = i_wr && (i_addr == `TASD_OFS_REF);
  wire wr_ovlp = i_wr && (i_addr == `TASD_OFS_OVLP);
  wire wr_steer = i_wr && (i_addr == `TASD_OFS_STEER);
  wire wr_ctrl = i_wr && (i_addr == `TASD_OFS_SWAP_CTRL);
  wire busy;
  wire req_edge;

  // ----------------------------------------
  // Fuse load after reset
  // ----------------------------------------
  // Loading one cycle after release keeps reset constant-only
  always @(posedge i_clk)
  begin
    if (i_srst)
      fuse_load_q <= 1'b1;
    else
      fuse_load_q <= 1'b0;
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      gain_q <= 8'h00;
      ref_q <= 4'h0;
    end
    else if (fuse_load_q)
    begin
      gain_q <= i_fuse_gain;
      ref_q <= i_fuse_ref;
    end
    else
    begin
      if (wr_gain)
        gain_q <= i_wdata;
      if (wr_ref)
        ref_q <= i_wdata[`TASD_REF_MSB:0];
    end
  end

  // ----------------------------------------
  // Per-channel termination trims
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_term
      // One register per channel keeps a single driver per trim
      localparam [31:0] TERM_OFS = `TASD_OFS_TERM_A + ch;
      wire wr_term = i_wr && (i_addr == TERM_OFS[ADDR_W-1:0]);
      reg [7:0] trim_q;
      always @(posedge i_clk)
      begin
        if (i_srst)
          trim_q <= 8'h00;
        else if (fuse_load_q)
          trim_q <= i_fuse_term[ch*8 +: 8];
        else if (wr_term)
          trim_q <= i_wdata;
      end
      assign o_termination_adjust[ch*8 +: 8] = trim_q;
    end
  endgenerate

  // ----------------------------------------
  // Swap delays and control
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ovlp_q <= `TASD_RST_OVLP;
      steer_q <= `TASD_RST_STEER;
      ctrl_q <= `TASD_RST_CTRL;
    end
    else
    begin
      // Write accepted always; the swap timer samples the delays only at swap start
      if (wr_ovlp)
        ovlp_q <= i_wdata[`TASD_DLY_MSB:0];
      if (wr_steer)
        steer_q <= i_wdata[`TASD_DLY_MSB:0];
      if (wr_ctrl)
        ctrl_q <= {7'h00, i_wdata[`TASD_CTRL_CAL_EN]};
    end
  end

  // Software swap trigger is a self-clearing pulse
  always @(posedge i_clk)
  begin
    if (i_srst)
      swap_go_q <= 1'b0;
    else
      swap_go_q <= wr_ctrl && i_wdata[`TASD_CTRL_SWAP_GO];
  end

  // ----------------------------------------
  // Swap request pin synchroniser
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      req_sync_q <= 3'b000;
      req_lvl_q <= 1'b0;
    end
    else
    begin
      req_sync_q <= {req_sync_q[1:0], i_swap_req};
      if (req_sync_q[1] == req_sync_q[2])
        req_lvl_q <= req_sync_q[2];
    end
  end

  reg req_lvl_prev_q;
  always @(posedge i_clk)
  begin
    if (i_srst)
      req_lvl_prev_q <= 1'b0;
    else
      req_lvl_prev_q <= req_lvl_q;
  end
  assign req_edge = req_lvl_q && !req_lvl_prev_q;

  // Swaps start only while calibration is enabled
  wire swap_start = ctrl_q[`TASD_CTRL_CAL_EN] && !busy && (swap_go_q || req_edge);

  tasd_swap_timer #(
    .CNT_W(`TASD_CNT_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(swap_start),
    .i_ovlp_dly(ovlp_q),
    .i_steer_dly(steer_q),
    .o_overlap(o_swap_overlap),
    .o_steer_wait(o_steer_wait),
    .o_steer_sel(o_steer_sel),
    .o_busy(busy)
  );

  assign o_swap_busy = busy;
  assign o_calibration_enable = ctrl_q[`TASD_CTRL_CAL_EN];
  assign o_core_gain_adjust = gain_q;
  assign o_reference_voltage_adjust = ref_q;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    rdata_d = 8'h00;
    case (i_addr)
      `TASD_OFS_GAIN: rdata_d = gain_q;
      `TASD_OFS_REF: rdata_d = {4'h0, ref_q};
      `TASD_OFS_TERM_A: rdata_d = o_termination_adjust[7:0];
      `TASD_OFS_TERM_B: rdata_d = o_termination_adjust[15:8];
      `TASD_OFS_TERM_C: rdata_d = o_termination_adjust[23:16];
      `TASD_OFS_TERM_D: rdata_d = o_termination_adjust[31:24];
      `TASD_OFS_OVLP: rdata_d = {3'h0, ovlp_q};
      `TASD_OFS_STEER: rdata_d = {3'h0, steer_q};
      `TASD_OFS_SWAP_CTRL: rdata_d = ctrl_q;
      `TASD_OFS_SWAP_STAT: rdata_d = {5'h00, busy, o_steer_wait, o_swap_overlap};
      default: rdata_d = 8'h00;
    endcase
  end

  // Data held between reads; only the cycle after a read is meaningful
  always @(posedge i_clk)
  begin
    if (i_srst)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rdata_d;
  end

endmodule

// file: hdl/tasd_swap_timer.v
// Purpose: Times one background core swap: overlap window, then steering switch delay
// Assumes: i_start is a one-cycle pulse from logic on i_clk
// Notes: Delay values are sampled at start so a mid-swap write cannot corrupt the window
`timescale 1ns/1ps
`include "tasd_defs.vh"

module tasd_swap_timer #(
  parameter CNT_W = `TASD_CNT_W
)(
  input wire i_clk,
  input wire i_srst,
  input wire i_start,
  input wire [4:0] i_ovlp_dly,
  input wire [4:0] i_steer_dly,
  output reg o_overlap,
  output reg o_steer_wait,
  output reg o_steer_sel,
  output wire o_busy
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OVLP = 3'b010;
  localparam [2:0] ST_STEER = 3'b100;

  reg [2:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg [4:0] steer_q;

  assign o_busy = ~state_q[0];

  // ----------------------------------------
  // Swap sequencer
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      steer_q <= 5'h00;
      o_overlap <= 1'b0;
      o_steer_wait <= 1'b0;
      o_steer_sel <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_start)
          begin
            // Both cores sample together for 4 + 2*delay cycles
            cnt_q <= `TASD_OVLP_BASE + {1'b0, i_ovlp_dly, 1'b0} - 7'h01;
            steer_q <= i_steer_dly;
            o_overlap <= 1'b1;
            state_q <= ST_OVLP;
          end
        end
        ST_OVLP:
        begin
          if (cnt_q == {CNT_W{1'b0}})
          begin
            o_overlap <= 1'b0;
            if (steer_q == 5'h00)
            begin
              o_steer_sel <= ~o_steer_sel;
              state_q <= ST_IDLE;
            end
            else
            begin
              cnt_q <= {2'b00, steer_q} - 7'h01;
              o_steer_wait <= 1'b1;
              state_q <= ST_STEER;
            end
          end
          else
            cnt_q <= cnt_q - 7'h01;
        end
        ST_STEER:
        begin
          if (cnt_q == {CNT_W{1'b0}})
          begin
            // Selector flips only after the programmed delay
            o_steer_sel <= ~o_steer_sel;
            o_steer_wait <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q - 7'h01;
        end
        default:
        begin
          state_q <= ST_IDLE;
          o_overlap <= 1'b0;
          o_steer_wait <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: tb/tasd_regs_chk.sv
// Purpose: Port-level checks of the trim and swap delay bank
// Assumes: One clock, synchronous reset
// Notes: Delay registers shadowed from observed writes
`timescale 1ns/1ps
`include "tasd_defs.vh"
module tasd_regs_chk #(
  parameter ADDR_W = `TASD_ADDR_W
)(
  input wire i_clk,
  input wire i_srst,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [7:0] i_fuse_gain,
  input wire [3:0] i_fuse_ref,
  input wire [31:0] i_fuse_term,
  input wire [7:0] o_core_gain_adjust,
  input wire [3:0] o_reference_voltage_adjust,
  input wire [31:0] o_termination_adjust,
  input wire o_calibration_enable,
  input wire o_swap_overlap,
  input wire o_steer_wait,
  input wire o_steer_sel,
  input wire o_swap_busy
);
  // ----
  // Shadows and run lengths
  // ----
  logic [4:0] ovl_q;
  logic [4:0] str_q;
  logic [7:0] ocnt_q;
  logic [7:0] scnt_q;
  always @(posedge i_clk)
  begin
    ocnt_q <= o_swap_overlap ? ocnt_q + 8'h01 : 8'h00;
    scnt_q <= o_steer_wait ? scnt_q + 8'h01 : 8'h00;
    if (i_srst)
    begin
      ovl_q <= `TASD_RST_OVLP;
      str_q <= `TASD_RST_STEER;
    end
    else if (i_wr && i_addr == `TASD_OFS_OVLP)
      ovl_q <= i_wdata[4:0];
    else if (i_wr && i_addr == `TASD_OFS_STEER)
      str_q <= i_wdata[4:0];
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ----
  // Properties
  // ----
  a_gain_write: assert property (i_wr && i_addr == `TASD_OFS_GAIN && !$past(i_srst)
    |=> o_core_gain_adjust == $past(i_wdata)) else $error("gain write lost");
  a_ref_write: assert property (i_wr && i_addr == `TASD_OFS_REF && !$past(i_srst)
    |=> o_reference_voltage_adjust == $past(i_wdata[3:0])) else $error("ref write lost");
  a_term_own: assert property (i_wr && i_addr == `TASD_OFS_TERM_B && !$past(i_srst)
    |=> o_termination_adjust == {$past(o_termination_adjust[31:16]), $past(i_wdata),
    $past(o_termination_adjust[7:0])}) else $error("term write spread");
  a_fuse_load: assert property ($fell(i_srst) |=> o_core_gain_adjust == i_fuse_gain &&
    o_reference_voltage_adjust == i_fuse_ref && o_termination_adjust == i_fuse_term)
    else $error("fuse values not loaded");
  a_read_back: assert property (i_rd && i_addr == `TASD_OFS_GAIN
    |=> o_rdata == $past(o_core_gain_adjust)) else $error("gain read wrong");
  a_ovlp_len: assert property ($fell(o_swap_overlap)
    |-> ocnt_q == 8'h04 + {2'h0, ovl_q, 1'b0}) else $error("overlap length wrong");
  a_steer_len: assert property ($fell(o_steer_wait)
    |-> scnt_q == {3'h0, str_q}) else $error("steer length wrong");
  a_sel_flip: assert property ($fell(o_swap_busy)
    |-> o_steer_sel != $past(o_steer_sel)) else $error("selector not toggled");
  a_no_cal: assert property (!o_calibration_enable && !o_swap_busy
    |=> !o_swap_busy) else $error("swap without calibration");
  a_ctrl_start: assert property (i_wr && i_addr == `TASD_OFS_SWAP_CTRL && i_wdata[1:0] == 2'h3
    && !o_swap_busy |-> ##2 o_swap_overlap && o_swap_busy) else $error("swap not started");
endmodule

bind tasd_regs tasd_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.i_clk, .i_srst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_fuse_gain, .i_fuse_ref, .i_fuse_term, .o_core_gain_adjust,
  .o_reference_voltage_adjust, .o_termination_adjust, .o_calibration_enable,
  .o_swap_overlap, .o_steer_wait, .o_steer_sel, .o_swap_busy);

// file: tb/test_tasd_regs.sv
// Purpose: Self-checking bench for the trim and swap delay bank
// Assumes: 25 MHz clock, reset held 5 cycles
// Notes: Byte model keyed by address; swap lengths counted at ports
`timescale 1ns/1ps
`include "tasd_defs.vh"
module test_tasd_regs;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_swap_req = 1'b0;
  logic [8:0] i_addr = 9'h000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_fuse_gain, o_rdata, o_core_gain_adjust;
  logic [3:0] i_fuse_ref, o_reference_voltage_adjust;
  logic [31:0] i_fuse_term, o_termination_adjust;
  logic o_calibration_enable, o_swap_overlap, o_steer_wait, o_steer_sel, o_swap_busy;
  logic [2:0] mon;
  logic sel_exp = 1'b0;
  logic [31:0] seed = 32'hA205E9B1;
  logic [7:0] mdl [int];
  logic [8:0] av [10] = '{9'h07A, 9'h07C, 9'h07E, 9'h07F, 9'h080, 9'h081, 9'h09A, 9'h09B,
    9'h07B, 9'h0A0};
  int err_total = 0;
  int n_compared = 0;
  int n;
  always #20 i_clk = ~i_clk;
  assign mon = {o_swap_busy, o_steer_wait, o_swap_overlap};
  tasd_regs u_tasd_regs (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_fuse_gain, .i_fuse_ref, .i_fuse_term, .o_core_gain_adjust, .o_reference_voltage_adjust,
    .o_termination_adjust, .i_swap_req, .o_calibration_enable, .o_swap_overlap,
    .o_steer_wait, .o_steer_sel, .o_swap_busy);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] msk(input logic [8:0] a);
    case (a)
      `TASD_OFS_REF: return 8'h0F;
      `TASD_OFS_OVLP, `TASD_OFS_STEER: return 8'h1F;
      `TASD_OFS_SWAP_CTRL: return 8'h01;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait on one monitor bit; n returns the cycles spent
  task automatic upto(input int b, input logic v, input int lim);
    n = 0;
    while (mon[b] !== v && n < lim)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (mon[b] !== v)
    begin
      chk("wait", v, mon[b]);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (mdl.exists(a))
      mdl[a] = d & msk(a);
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", mdl.exists(a) ? mdl[a] : 8'h00, o_rdata);
  endtask
  task automatic outs();
    #1;
    chk("gain", mdl[av[0]], o_core_gain_adjust);
    chk("ref", mdl[av[1]], o_reference_voltage_adjust);
    chk("term", {mdl[av[5]], mdl[av[4]], mdl[av[3]], mdl[av[2]]}, o_termination_adjust);
    chk("cal", mdl[av[9]], o_calibration_enable);
  endtask
  // Delays are set before the trigger; changing them mid-swap is software's fault
  task automatic sw(input logic [7:0] ov, input logic [7:0] st);
    wr(`TASD_OFS_SWAP_CTRL, 8'h00);
    wr(`TASD_OFS_OVLP, ov);
    wr(`TASD_OFS_STEER, st);
    wr(`TASD_OFS_SWAP_CTRL, 8'h03);
    #1;
    upto(0, 1'b1, 8);
    upto(0, 1'b0, 200);
    chk("overlap", 4 + 2 * ov, n);
    upto(1, 1'b0, 200);
    chk("steer", st, n);
    chk("busy", 1'b0, o_swap_busy);
    sel_exp = ~sel_exp;
    chk("sel", sel_exp, o_steer_sel);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    i_fuse_term = xs();
    n = xs();
    i_fuse_gain = n[7:0];
    i_fuse_ref = n[11:8];
    mdl[av[0]] = i_fuse_gain;
    mdl[av[1]] = {4'h0, i_fuse_ref};
    for (int k = 0; k < 4; k++)
      mdl[av[k + 2]] = i_fuse_term[8 * k +: 8];
    mdl[av[6]] = 8'h08;
    mdl[av[7]] = 8'h07;
    mdl[av[9]] = 8'h00;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int k = 0; k < 10; k++)
      rd(av[k]);
    outs();
    for (int k = 0; k < 27; k++)
    begin
      n = xs();
      // Reserved bits written as zero; gain trim written over its full 8-bit scale
      wr(av[k % 9], n[7:0] & msk(av[k % 9]));
      outs();
      rd(av[k % 9]);
    end
    sw(8'h00, 8'h01);
    sw(8'h07, 8'h00);
    sw(8'h1F, 8'h03);
    wr(`TASD_OFS_SWAP_CTRL, 8'h02);
    repeat (6) @(posedge i_clk);
    #1;
    chk("idle", 1'b0, o_swap_busy);
    wr(`TASD_OFS_SWAP_CTRL, 8'h01);
    i_swap_req <= 1'b1;
    #1;
    upto(2, 1'b1, 20);
    chk("pin", 1'b1, o_swap_busy);
    upto(2, 1'b0, 200);
    sel_exp = ~sel_exp;
    chk("sel", sel_exp, o_steer_sel);
    outs();
    @(posedge i_clk);
    i_swap_req <= 1'b0;
    end_of_test();
  end
endmodule
